// File: pkg/brd_params.svh
// What this block does
// - Hold processor reset over 100 ms.
// - Keys 1 and 3 at power-up: card boot.
// - Boot flip-flop swaps flash and card selects.
// - Processor IO stays input during reset.
// - Hold data lines 4 and 9 low in reset.
// - Display blanked until software sets unblank.
// - Software waits 2 ms between display cycles.
// - Any pressed key raises key interrupt.
// - Four travelling-low columns, eight latched rows.
// - Processor decodes key from 12-bit word.
// - Encoder interrupt and direction passed buffered.
// - GPIB clock is system clock divided by 4.
// - Processor clock slow in reset, fast after.
// - Processor may copy card firmware into flash.
// - Completed VXI access drives acknowledge low.
// - Processor aborts unanswered VXI cycle by timeout.
// - Logic programming access only while enabled.
// - Firmware toggles beeper; board drives inverse.
// - Display buffer off while bus used elsewhere.
`ifndef BRD_PARAMS_SVH
`define BRD_PARAMS_SVH
`define BRD_CLK_HZ 10000000
`define BRD_RESET_MS 100
`define BRD_RESET_CYCLES (`BRD_RESET_MS * (`BRD_CLK_HZ / 1000) + 1)
`define BRD_DISP_GAP_MS 2
`define BRD_DISP_GAP_CYCLES ((`BRD_DISP_GAP_MS * `BRD_CLK_HZ + 999) / 1000)
`define BRD_GPIB_DIV 4
`define BRD_SCAN_CYCLES 64
`define BRD_VXI_TIMEOUT 256
`define BRD_KEY_COLS 4
`define BRD_KEY_ROWS 8
`define BRD_KEY1_COL 0
`define BRD_KEY1_ROW 0
`define BRD_KEY3_COL 0
`define BRD_KEY3_ROW 2
`define BRD_REG_CTRL 32'h0000_0000
`define BRD_REG_STATUS 32'h0000_0004
`define BRD_REG_VXI 32'h0000_0008
`define BRD_REG_BEEP 32'h0000_000C
`define BRD_REG_DISP 32'h0000_0010
`define BRD_CTRL_RESET 16'h000C
`define BRD_CTRL_PROG_BIT 0
`define BRD_CTRL_BEEP_BIT 1
`define BRD_CTRL_CSB_BIT 2
`define BRD_CTRL_CSA_BIT 3
`define BRD_CTRL_GPIO_LSB 8
`define BRD_RESP_OKAY 2'h0
`define BRD_RESP_SLVERR 2'h2
`endif

// File: pkg/brd_pkg.sv
package brd_pkg;
  typedef enum logic [1:0] {VXI_IDLE, VXI_BUSY, VXI_ACK} brd_vxi_e;
  typedef logic [11:0] brd_key_word_t;
endpackage

// File: pkg/brd_if.sv
`timescale 1ns/1ps
interface brd_if;
  logic cpu_reset;
  logic mode_oe;
  logic [1:0] mode_out;
  logic [1:0] mode_level;
  brd_pkg::brd_key_word_t key_word;
  logic key_irq;
  logic enc_irq;
  logic enc_dir;
  logic disp_wr;
  logic disp_data;
  logic bus_other;
  logic beep_pin;
  logic cs_boot_n;
  logic cs_alt_n;
  logic prog_en;
  logic vxi_req;
  logic ack_n;
  assign mode_level = mode_oe ? mode_out : 2'h3;
  modport dev(output cpu_reset, mode_oe, mode_out, key_word, key_irq, enc_irq, enc_dir, ack_n,
              input disp_wr, disp_data, bus_other, beep_pin, cs_boot_n, cs_alt_n, prog_en,
              vxi_req);
  modport cpu(input cpu_reset, mode_level, key_word, key_irq, enc_irq, enc_dir, ack_n,
              output disp_wr, disp_data, bus_other, beep_pin, cs_boot_n, cs_alt_n, prog_en,
              vxi_req);
endinterface

// File: logic/brd_board_end.sv
`timescale 1ns/1ps
`include "brd_params.svh"
module brd_board_end #(
  parameter int RESET_CYCLES = `BRD_RESET_CYCLES,
  parameter int KEY_COLS = `BRD_KEY_COLS,
  parameter int KEY_ROWS = `BRD_KEY_ROWS,
  parameter int SCAN_CYCLES = `BRD_SCAN_CYCLES
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  brd_if.dev bus,
  input wire logic [KEY_ROWS-1:0] KEY_ROW_N_IN,
  output logic [KEY_COLS-1:0] KEY_COL_N_OUT,
  input wire logic ENC_IRQ_IN,
  input wire logic ENC_DIR_IN,
  input wire logic VXI_DONE_IN,
  output logic VXI_STROBE_OUT,
  output logic DISPLAY_UNBLANK_OUT,
  output logic DISP_BUF_EN_OUT,
  output logic BEEP_A_OUT,
  output logic BEEP_B_OUT,
  output logic FLASH_CS_N_OUT,
  output logic CARD_CS_N_OUT,
  output logic GPIB_CLK_OUT,
  output logic CPU_CLK_FAST_OUT,
  output logic PROG_ACCESS_EN_OUT
);
  import brd_pkg::*;
  localparam int CW = $clog2(KEY_COLS);

  typedef struct packed {
    logic [31:0] rst_cnt;
    logic cpu_reset;
    logic boot_card;
    logic key1;
    logic key3;
    logic [CW-1:0] col_idx;
    logic [KEY_COLS-1:0] col_n;
    logic [15:0] scan_cnt;
    logic [KEY_ROWS-1:0] row_s1;
    logic [KEY_ROWS-1:0] row_s2;
    brd_key_word_t key_word;
    logic press_acc;
    logic key_irq;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic enc_irq;
    logic enc_dir;
    brd_vxi_e vxi;
    logic vxi_strobe;
    logic ack_n;
    logic [1:0] gdiv;
    logic gpib_clk;
    logic unblank;
    logic buf_en;
    logic beep_a;
    logic beep_b;
    logic flash_cs_n;
    logic card_cs_n;
    logic prog_en;
    logic fast;
  } brd_dev_s;

  brd_dev_s r;
  brd_dev_s n;
  logic pressed;

  function automatic logic last_col(input logic [CW-1:0] idx);
    last_col = (idx == CW'(KEY_COLS - 1));
  endfunction

  function automatic logic [KEY_COLS-1:0] col_drive(input logic [CW-1:0] idx);
    col_drive = ~(KEY_COLS'(1) << idx);
  endfunction

  always_comb begin
    n = r;
    pressed = ~&r.row_s2;
    n.row_s1 = KEY_ROW_N_IN;
    n.row_s2 = r.row_s1;
    n.pin_s1 = {VXI_DONE_IN, ENC_DIR_IN, ENC_IRQ_IN};
    n.pin_s2 = r.pin_s1;
    n.enc_irq = r.pin_s2[0];
    n.enc_dir = r.pin_s2[1];
    // Reset counter runs once after power-up and then stops.
    if (r.rst_cnt < RESET_CYCLES) begin
      n.rst_cnt = r.rst_cnt + 32'h0000_0001;
    end
    n.cpu_reset = (r.rst_cnt < RESET_CYCLES);
    n.fast = ~n.cpu_reset;
    // The boot choice is taken only at the end of the power-up reset.
    if (r.cpu_reset && !n.cpu_reset) begin
      n.boot_card = r.key1 & r.key3;
    end
    if (r.scan_cnt == 16'(SCAN_CYCLES - 1)) begin
      n.scan_cnt = 16'h0000;
      n.key_word = {r.col_n, r.row_s2};
      n.press_acc = r.press_acc | pressed;
      if (last_col(r.col_idx)) begin
        n.key_irq = r.press_acc | pressed;
        n.press_acc = 1'b0;
      end
      if (r.cpu_reset) begin
        if (r.col_idx == CW'(`BRD_KEY1_COL)) begin
          n.key1 = ~r.row_s2[`BRD_KEY1_ROW];
        end
        if (r.col_idx == CW'(`BRD_KEY3_COL)) begin
          n.key3 = ~r.row_s2[`BRD_KEY3_ROW];
        end
      end
      if (last_col(r.col_idx)) begin
        n.col_idx = '0;
      end else begin
        n.col_idx = r.col_idx + CW'(1);
      end
      n.col_n = col_drive(n.col_idx);
    end else begin
      n.scan_cnt = r.scan_cnt + 16'h0001;
    end
    // The GPIB clock toggles once every half division.
    if (r.gdiv == 2'(`BRD_GPIB_DIV / 2 - 1)) begin
      n.gdiv = 2'h0;
      n.gpib_clk = ~r.gpib_clk;
    end else begin
      n.gdiv = r.gdiv + 2'h1;
    end
    if (bus.disp_wr) begin
      n.unblank = bus.disp_data;
    end
    n.buf_en = ~bus.bus_other;
    n.beep_a = bus.beep_pin;
    n.beep_b = ~bus.beep_pin;
    // Card firmware can be copied because both regions stay reachable.
    n.flash_cs_n = r.boot_card ? bus.cs_alt_n : bus.cs_boot_n;
    n.card_cs_n = r.boot_card ? bus.cs_boot_n : bus.cs_alt_n;
    n.prog_en = bus.prog_en & ~r.cpu_reset;
    // Completion handshake for one VXI access at a time.
    unique case (r.vxi)
      VXI_IDLE: begin
        if (bus.vxi_req) begin
          n.vxi = VXI_BUSY;
          n.vxi_strobe = 1'b1;
        end
      end
      VXI_BUSY: begin
        if (!bus.vxi_req) begin
          n.vxi = VXI_IDLE;
          n.vxi_strobe = 1'b0;
        end else if (r.pin_s2[2]) begin
          n.vxi = VXI_ACK;
          n.vxi_strobe = 1'b0;
          n.ack_n = 1'b0;
        end
      end
      VXI_ACK: begin
        if (!bus.vxi_req) begin
          n.vxi = VXI_IDLE;
          n.ack_n = 1'b1;
        end
      end
      default: begin
        n.vxi = VXI_IDLE;
        n.vxi_strobe = 1'b0;
        n.ack_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      r <= '0;
      r.cpu_reset <= 1'b1;
      r.col_n <= ~(KEY_COLS'(1));
      r.row_s1 <= '1;
      r.row_s2 <= '1;
      r.key_word <= '1;
      r.vxi <= VXI_IDLE;
      r.ack_n <= 1'b1;
      r.buf_en <= 1'b1;
      r.beep_b <= 1'b1;
      r.flash_cs_n <= 1'b1;
      r.card_cs_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign KEY_COL_N_OUT = r.col_n;
  assign VXI_STROBE_OUT = r.vxi_strobe;
  assign DISPLAY_UNBLANK_OUT = r.unblank;
  assign DISP_BUF_EN_OUT = r.buf_en;
  assign BEEP_A_OUT = r.beep_a;
  assign BEEP_B_OUT = r.beep_b;
  assign FLASH_CS_N_OUT = r.flash_cs_n;
  assign CARD_CS_N_OUT = r.card_cs_n;
  assign GPIB_CLK_OUT = r.gpib_clk;
  assign CPU_CLK_FAST_OUT = r.fast;
  assign PROG_ACCESS_EN_OUT = r.prog_en;
  assign bus.cpu_reset = r.cpu_reset;
  assign bus.mode_oe = r.cpu_reset;
  assign bus.mode_out = 2'h0;
  assign bus.key_word = r.key_word;
  assign bus.key_irq = r.key_irq;
  assign bus.enc_irq = r.enc_irq;
  assign bus.enc_dir = r.enc_dir;
  assign bus.ack_n = r.ack_n;
endmodule

// File: logic/brd_cpu_end.sv
`timescale 1ns/1ps
`include "brd_params.svh"
module brd_cpu_end #(
  parameter int DISP_GAP_CYCLES = `BRD_DISP_GAP_CYCLES,
  parameter int VXI_TIMEOUT = `BRD_VXI_TIMEOUT,
  parameter int GPIO_W = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  brd_if.cpu bus,
  input wire logic [31:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [31:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [GPIO_W-1:0] GPIO_OUT,
  output logic [GPIO_W-1:0] GPIO_OE_OUT
);
  import brd_pkg::*;

  typedef struct packed {
    logic aw_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] ctrl;
    logic [15:0] beep_div;
    logic [15:0] beep_cnt;
    logic beep_pin;
    logic [31:0] gap;
    logic disp_wr;
    logic disp_data;
    brd_vxi_e vxi;
    logic vxi_req;
    logic [31:0] vxi_cnt;
    logic vxi_done;
    logic vxi_to;
    logic [1:0] mode;
    logic rst_seen;
    logic [GPIO_W-1:0] gpio_oe;
  } brd_cpu_s;

  brd_cpu_s r;
  brd_cpu_s n;
  logic [31:0] wa;
  logic [31:0] ra;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [31:0] word_addr(input logic [31:0] a);
    word_addr = {a[31:2], 2'h0};
  endfunction

  always_comb begin
    n = r;
    n.disp_wr = 1'b0;
    wa = word_addr(S_AXI_AWADDR_IN);
    ra = word_addr(S_AXI_ARADDR_IN);
    if (r.gap != 32'h0000_0000) begin
      n.gap = r.gap - 32'h0000_0001;
    end
    unique case (r.vxi)
      VXI_IDLE: begin
      end
      VXI_BUSY: begin
        if (!bus.ack_n) begin
          n.vxi = VXI_IDLE;
          n.vxi_done = 1'b1;
        end else if (r.vxi_cnt == 32'(VXI_TIMEOUT - 1)) begin
          n.vxi = VXI_IDLE;
          n.vxi_to = 1'b1;
        end else begin
          n.vxi_cnt = r.vxi_cnt + 32'h0000_0001;
        end
      end
      default: begin
        n.vxi = VXI_IDLE;
      end
    endcase
    if (!r.aw_rdy && !r.bvalid && S_AXI_AWVALID_IN && S_AXI_WVALID_IN) begin
      n.aw_rdy = 1'b1;
    end
    if (r.aw_rdy) begin
      n.aw_rdy = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `BRD_RESP_OKAY;
      if (wa == `BRD_REG_CTRL) begin
        n.ctrl = merge16(r.ctrl, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
      end else if (wa == `BRD_REG_VXI) begin
        if (S_AXI_WDATA_IN[0] && S_AXI_WSTRB_IN[0] && r.vxi == VXI_IDLE) begin
          n.vxi = VXI_BUSY;
          n.vxi_cnt = 32'h0000_0000;
          n.vxi_done = 1'b0;
          n.vxi_to = 1'b0;
        end
      end else if (wa == `BRD_REG_BEEP) begin
        n.beep_div = merge16(r.beep_div, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
      end else if (wa == `BRD_REG_DISP && S_AXI_WSTRB_IN[0]) begin
        if (r.gap == 32'h0000_0000) begin
          n.disp_wr = 1'b1;
          n.disp_data = S_AXI_WDATA_IN[0];
          n.gap = 32'(DISP_GAP_CYCLES);
        end else begin
          n.bresp = `BRD_RESP_SLVERR;
        end
      end else if (wa != `BRD_REG_DISP) begin
        n.bresp = `BRD_RESP_SLVERR;
      end
    end
    if (r.bvalid && S_AXI_BREADY_IN) begin
      n.bvalid = 1'b0;
    end
    if (!r.ar_rdy && !r.rvalid && S_AXI_ARVALID_IN) begin
      n.ar_rdy = 1'b1;
    end
    if (r.ar_rdy) begin
      n.ar_rdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = `BRD_RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if (ra == `BRD_REG_CTRL) begin
        n.rdata = {16'h0000, r.ctrl};
      end else if (ra == `BRD_REG_STATUS) begin
        // Key word is decoded by software from its row and column bits.
        n.rdata = {13'h0000, (r.gap != 32'h0000_0000), r.mode, bus.cpu_reset, bus.enc_dir,
                   bus.enc_irq, bus.key_irq, bus.key_word};
      end else if (ra == `BRD_REG_VXI) begin
        n.rdata = {29'h0000_0000, r.vxi_to, r.vxi_done, (r.vxi != VXI_IDLE)};
      end else if (ra == `BRD_REG_BEEP) begin
        n.rdata = {16'h0000, r.beep_div};
      end else if (ra == `BRD_REG_DISP) begin
        n.rdata = {31'h0000_0000, r.disp_data};
      end else begin
        n.rresp = `BRD_RESP_SLVERR;
      end
    end
    if (r.rvalid && S_AXI_RREADY_IN) begin
      n.rvalid = 1'b0;
    end
    if (r.ctrl[`BRD_CTRL_BEEP_BIT]) begin
      if (r.beep_cnt >= r.beep_div) begin
        n.beep_cnt = 16'h0000;
        n.beep_pin = ~r.beep_pin;
      end else begin
        n.beep_cnt = r.beep_cnt + 16'h0001;
      end
    end else begin
      n.beep_cnt = 16'h0000;
      n.beep_pin = 1'b0;
    end
    // Mode lines are sampled while the board holds them, applied at release.
    n.rst_seen = bus.cpu_reset;
    if (bus.cpu_reset) begin
      n.mode = bus.mode_level;
      n.gpio_oe = '0;
    end else if (r.rst_seen) begin
      n.gpio_oe = (r.mode == 2'h0) ? '1 : '0;
    end
    n.vxi_req = (n.vxi == VXI_BUSY);
  end

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      r <= '0;
      r.ctrl <= `BRD_CTRL_RESET;
      r.vxi <= VXI_IDLE;
      r.mode <= 2'h3;
      r.rst_seen <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign S_AXI_AWREADY_OUT = r.aw_rdy;
  assign S_AXI_WREADY_OUT = r.aw_rdy;
  assign S_AXI_BRESP_OUT = r.bresp;
  assign S_AXI_BVALID_OUT = r.bvalid;
  assign S_AXI_ARREADY_OUT = r.ar_rdy;
  assign S_AXI_RDATA_OUT = r.rdata;
  assign S_AXI_RRESP_OUT = r.rresp;
  assign S_AXI_RVALID_OUT = r.rvalid;
  assign GPIO_OUT = r.ctrl[`BRD_CTRL_GPIO_LSB +: GPIO_W];
  assign GPIO_OE_OUT = r.gpio_oe;
  assign bus.disp_wr = r.disp_wr;
  assign bus.disp_data = r.disp_data;
  assign bus.bus_other = r.vxi_req;
  assign bus.vxi_req = r.vxi_req;
  assign bus.beep_pin = r.beep_pin;
  assign bus.cs_boot_n = r.ctrl[`BRD_CTRL_CSB_BIT];
  assign bus.cs_alt_n = r.ctrl[`BRD_CTRL_CSA_BIT];
  assign bus.prog_en = r.ctrl[`BRD_CTRL_PROG_BIT];
endmodule

// File: bench/brd_monitor.sv
`timescale 1ns/1ps
module brd_monitor #(
  parameter int RESET_CYCLES = 50,
  parameter int DISP_GAP_CYCLES = 20
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic cpu_reset,
  input wire logic mode_oe,
  input wire logic [1:0] mode_level,
  input wire brd_pkg::brd_key_word_t key_word,
  input wire logic key_irq,
  input wire logic disp_wr,
  input wire logic bus_other,
  input wire logic vxi_req,
  input wire logic ack_n
);
  import brd_pkg::*;
  int rel_cnt;
  int gap_cnt;
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  // Counts cycles since reset release and since the last display cycle.
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rel_cnt <= 0;
      gap_cnt <= DISP_GAP_CYCLES;
    end else begin
      rel_cnt <= (rel_cnt < 1000) ? rel_cnt + 1 : rel_cnt;
      gap_cnt <= disp_wr ? 1 : ((gap_cnt < DISP_GAP_CYCLES) ? gap_cnt + 1 : gap_cnt);
    end
  end
  sequence key_seen;
    !cpu_reset && key_word[7:0] != 8'hFF;
  endsequence
  sequence ack_seen;
    $fell(ack_n);
  endsequence
  reset_hold_a: assert property ((rel_cnt < RESET_CYCLES) |-> cpu_reset)
    else $error("processor reset released early");
  reset_once_a: assert property (!cpu_reset |=> !cpu_reset)
    else $error("processor reset came back");
  mode_low_a: assert property (cpu_reset |-> mode_oe && mode_level == 2'h0)
    else $error("mode lines not low in reset");
  mode_free_a: assert property ($fell(cpu_reset) |-> !mode_oe)
    else $error("mode lines still driven");
  one_col_a: assert property (!cpu_reset |-> $onehot(~key_word[11:8]))
    else $error("column word not one low");
  key_irq_a: assert property (key_seen |-> ##[0:80] key_irq)
    else $error("key interrupt missing");
  disp_pulse_a: assert property (disp_wr |=> !disp_wr)
    else $error("display write too long");
  disp_gap_a: assert property (disp_wr |-> gap_cnt >= DISP_GAP_CYCLES - 1)
    else $error("display cycles too close");
  ack_order_a: assert property (ack_seen |-> vxi_req ##[1:2] !vxi_req ##[0:2] ack_n)
    else $error("acknowledge sequence wrong");
  vxi_bound_a: assert property ($rose(vxi_req) |-> ##[1:40] !vxi_req)
    else $error("bus cycle not ended");
  buf_share_a: assert property (bus_other == vxi_req)
    else $error("bus use flag differs");
endmodule

// File: bench/processor_board_glue_logic_tb_top.sv
`timescale 1ns/1ps
module processor_board_glue_logic_tb_top;
  import brd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rows_n = 8'hFF;
  logic [7:0] row_acc;
  logic [3:0] cols_n;
  logic enc_irq = 1'b0;
  logic enc_dir = 1'b0;
  logic vxi_done = 1'b0;
  logic strobe, unblank, buf_en, beep_a, beep_b, flash_n, card_n, gpib, fast, prog;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] rdata;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] gpio, gpio_oe;
  logic [31:0] pressed = 32'h0;
  logic [31:0] seed;
  logic [31:0] v;
  logic [15:0] g;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  brd_if bus_i();
  brd_board_end #(.RESET_CYCLES(50), .SCAN_CYCLES(8)) u_brd_board_end (.REF_CLK_IN(clk),
    .RESET_IN(rst), .bus(bus_i.dev), .KEY_ROW_N_IN(rows_n), .KEY_COL_N_OUT(cols_n),
    .ENC_IRQ_IN(enc_irq), .ENC_DIR_IN(enc_dir), .VXI_DONE_IN(vxi_done),
    .VXI_STROBE_OUT(strobe), .DISPLAY_UNBLANK_OUT(unblank), .DISP_BUF_EN_OUT(buf_en),
    .BEEP_A_OUT(beep_a), .BEEP_B_OUT(beep_b), .FLASH_CS_N_OUT(flash_n),
    .CARD_CS_N_OUT(card_n), .GPIB_CLK_OUT(gpib), .CPU_CLK_FAST_OUT(fast),
    .PROG_ACCESS_EN_OUT(prog));
  brd_cpu_end #(.DISP_GAP_CYCLES(20), .VXI_TIMEOUT(16)) u_brd_cpu_end (.REF_CLK_IN(clk),
    .RESET_IN(rst), .bus(bus_i.cpu), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .GPIO_OUT(gpio), .GPIO_OE_OUT(gpio_oe));
  brd_monitor u_brd_monitor (.REF_CLK_IN(clk),
    .RESET_IN(rst), .cpu_reset(bus_i.cpu_reset), .mode_oe(bus_i.mode_oe),
    .mode_level(bus_i.mode_level), .key_word(bus_i.key_word), .key_irq(bus_i.key_irq),
    .disp_wr(bus_i.disp_wr), .bus_other(bus_i.bus_other), .vxi_req(bus_i.vxi_req),
    .ack_n(bus_i.ack_n));
  always #50 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // The key matrix answers the column that is driven low.
  always @(posedge clk) begin
    row_acc = 8'hFF;
    for (int c = 0; c < 4; c++) begin
      if (cols_n[c] === 1'b0) begin
        row_acc = row_acc & ~pressed[c*8 +: 8];
      end
    end
    rows_n <= row_acc;
  end
  // Takes the oldest expected answer whenever a response is handed over.
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready) begin
      chk({30'h0, rresp}, {30'h0, rq[0][65:64]});
      chk(rdata & rq[0][63:32], rq[0][31:0]);
      void'(rq.pop_front());
    end
    if (bvalid === 1'b1 && bready) begin
      chk({30'h0, bresp}, {30'h0, bq.pop_front()});
    end
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    rq.push_back({r, m, e & m});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic do_reset(input logic [31:0] keys);
    pressed <= keys;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk({31'h0, fast}, 32'h0);
    chk({31'h0, unblank}, 32'h0);
    chk({24'h0, gpio_oe}, 32'h0);
    n = 10;
    while (fast !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= 50}, 32'h1);
    repeat (2) @(posedge clk);
    chk({24'h0, gpio_oe}, 32'hFF);
    rd(32'h0, 32'h000C, 32'hFFFF, 2'h0);
  endtask
  initial begin
    seed = 32'h8355;
    do_reset(32'h5);
    pressed <= 32'h0;
    wr(32'h0, 32'h8, 2'h0);
    repeat (40) @(posedge clk);
    chk({30'h0, flash_n, card_n}, 32'h2);
    do_reset(32'h0);
    wr(32'h0, 32'h8, 2'h0);
    repeat (2) @(posedge clk);
    chk({30'h0, flash_n, card_n}, 32'h1);
    v = xs(seed);
    seed = v;
    wr(32'hC, 32'h3, 2'h0);
    wr(32'h0, {16'h0, v[15:8], 8'h0B}, 2'h0);
    rd(32'h0, {16'h0, v[15:8], 8'h0B}, 32'hFFFF, 2'h0);
    repeat (2) @(posedge clk);
    chk({24'h0, gpio}, {24'h0, v[15:8]});
    chk({31'h0, prog}, 32'h1);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      chk({31'h0, beep_b}, {31'h0, ~beep_a});
      n += int'(beep_a !== g[0]);
      g[0] = beep_a;
    end
    chk({31'h0, n > 4}, 32'h1);
    wr(32'h0, 32'h8, 2'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, prog}, 32'h0);
    wstrb <= 4'h2;
    wr(32'h0, {16'h0, ~v[15:8], 8'hF7}, 2'h0);
    wstrb <= 4'hF;
    rd(32'h0, {16'h0, ~v[15:8], 8'h08}, 32'hFFFF, 2'h0);
    rd(32'h40, 32'h0, 32'hFFFF_FFFF, 2'h2);
    wr(32'h40, 32'h0, 2'h2);
    wr(32'h10, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, unblank}, 32'h1);
    wr(32'h10, 32'h0, 2'h2);
    repeat (22) @(posedge clk);
    chk({31'h0, unblank}, 32'h1);
    wr(32'h10, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, unblank}, 32'h0);
    v = xs(seed);
    seed = v;
    pressed <= 32'h1 << v[4:0];
    enc_irq <= 1'b1;
    enc_dir <= v[5];
    repeat (80) @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      if (bus_i.key_word[8 + c] === 1'b0) begin
        chk({24'h0, bus_i.key_word[7:0]}, {24'h0, ~pressed[c*8 +: 8]});
      end
    end
    rd(32'h4, {17'h0, v[5], 2'h3, 12'h0}, 32'h7000, 2'h0);
    pressed <= 32'h0;
    enc_irq <= 1'b0;
    repeat (80) @(posedge clk);
    rd(32'h4, 32'h0, 32'h3000, 2'h0);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      g[i] = gpib;
    end
    chk({20'h0, g[11:0]}, {20'h0, g[15:4]});
    chk($countones(g[3:0]), 32'h2);
    wr(32'h8, 32'h1, 2'h0);
    while (strobe !== 1'b1) @(posedge clk);
    chk({31'h0, buf_en}, 32'h0);
    vxi_done <= 1'b1;
    while (strobe !== 1'b0) @(posedge clk);
    repeat (4) @(posedge clk);
    vxi_done <= 1'b0;
    rd(32'h8, 32'h2, 32'h7, 2'h0);
    wr(32'h8, 32'h1, 2'h0);
    repeat (30) @(posedge clk);
    chk({31'h0, strobe}, 32'h0);
    rd(32'h8, 32'h4, 32'h5, 2'h0);
    repeat (4) @(posedge clk);
    conclude();
  end
  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end
endmodule
